// ---- logic/flash_sec_pkg.sv ----
package flash_sec_pkg;
  localparam logic [7:0] SFR_PSC_ADDR = 8'h8F;
  localparam logic [7:0] SFR_SCALE_ADDR = 8'hB6;
  localparam logic [7:0] SFR_KEY_ADDR = 8'hB7;
  localparam logic [1:0] PSC_RESET = 2'h0;
  localparam logic RT_RESET = 1'b0;
  localparam int WE_BIT = 0;
  localparam int EE_BIT = 1;
  localparam int RT_BIT = 4;
  localparam logic [7:0] KEY_CODE1 = 8'hA5;
  localparam logic [7:0] KEY_CODE2 = 8'hF1;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int FLASH_AW = 13;
  localparam int PAGE_LSB = 9;
  localparam int PAGE_BYTES = 512;
  localparam int FLASH_BYTES = 8192;
  localparam logic [12:0] LOCK_ADDR = 13'h1DFF;
  localparam logic [3:0] LOCK_PAGE = 4'hE;
  localparam logic [3:0] RSVD_PAGE = 4'hF;
  localparam int CLK_PERIOD_NS = 50;
  localparam int WRITE_MIN_US = 40;
  localparam int ERASE_MIN_MS = 10;
  localparam int WRITE_CYC_DEF =
    (WRITE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC_DEF =
    (ERASE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {KEY_LOCKED, KEY_FIRST, KEY_OPEN, KEY_DEAD}
    key_state_t;
  typedef struct packed {
    logic we;
    logic set_ff;
    logic re;
    logic [12:0] addr;
    logic [7:0] wdata;
  } mem_cmd_t;
endpackage

// ---- logic/flash_store.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_store
  import flash_sec_pkg::*;
#(
  parameter int DEPTH = flash_sec_pkg::FLASH_BYTES
) (
  input wire logic i_ref_clk,               // Core clock
  input wire flash_sec_pkg::mem_cmd_t i_cmd, // Access command
  output logic [7:0] o_rdata                 // Registered read data
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_ff;

  // Programming only pulls bits low; only set_ff restores ones
  // Contents outlive reset and may be preset from outside: no always_ff
  always @(posedge i_ref_clk)
  begin
    if (i_cmd.set_ff)
      mem[i_cmd.addr] <= ERASED_BYTE;
    else if (i_cmd.we)
      mem[i_cmd.addr] <= mem[i_cmd.addr] & i_cmd.wdata;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_cmd.re)
      rdata_ff <= mem[i_cmd.addr];
  end

  assign o_rdata = rdata_ff;
endmodule
`default_nettype wire

// ---- logic/flash_write_erase_security.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_write_erase_security #(
  parameter int WRITE_CYCLES = flash_sec_pkg::WRITE_CYC_DEF,
  parameter int ERASE_CYCLES = flash_sec_pkg::ERASE_CYC_DEF
) (
  input wire logic i_ref_clk,           // Core clock, 20 MHz
  input wire logic i_rst_n,             // Async reset, active low
  input wire logic i_sfr_wr,            // Register write strobe
  input wire logic i_sfr_rd,            // Register read strobe
  input wire logic [7:0] i_sfr_addr,    // Register address
  input wire logic [7:0] i_sfr_wdata,   // Register write data
  output logic [7:0] o_sfr_rdata,       // Register read data
  input wire logic [15:0] i_pc,         // Executing instruction address
  input wire logic i_cmem_rd,           // Code-memory read strobe
  input wire logic [15:0] i_cmem_addr,  // Code-memory read address
  input wire logic i_dmem_wr,           // Data-memory write strobe
  input wire logic [15:0] i_dmem_addr,  // Data-memory write address
  input wire logic [7:0] i_dmem_wdata,  // Data-memory write data
  output logic o_external_data_ram_wr,               // Write goes to external RAM
  output logic o_stall,                 // Core must hold
  output logic o_code_valid,            // Code read data valid
  input wire logic i_dbg_rd,            // Debug read request
  input wire logic i_dbg_wr,            // Debug byte program request
  input wire logic i_dbg_erase,         // Debug page erase request
  input wire logic i_dbg_dev_erase,     // Debug whole-device erase
  input wire logic [12:0] i_dbg_addr,   // Debug target address
  input wire logic [7:0] i_dbg_wdata,   // Debug program data
  output logic o_dbg_ready,             // Debug request taken
  output logic o_dbg_valid,             // Debug read data valid
  output logic o_dbg_refused,           // Debug request blocked
  output logic [7:0] o_flash_rdata,     // Flash read data
  output logic o_flash_err,             // Flash-error reset pulse
  output logic o_read_time_sel          // Flash read timing select
);
  import flash_sec_pkg::*;

  typedef enum logic [2:0] {ST_BOOT, ST_BOOT_LD, ST_IDLE, ST_PROG,
                            ST_ERASE, ST_DEV_ERASE} state_t;
  localparam int TMR_W = $clog2(ERASE_CYCLES + WRITE_CYCLES + 1);

  state_t state_ff, nxt_state;
  key_state_t key_ff, nxt_key;
  logic [1:0] ctl_ff, nxt_ctl;
  logic rt_ff, nxt_rt;
  logic [7:0] lock_ff, nxt_lock;
  logic [TMR_W-1:0] tmr_ff, nxt_tmr;
  logic [3:0] base_ff, nxt_base;
  logic [7:0] sfr_rdata_ff, nxt_sfr_rdata;
  logic code_valid_ff, nxt_code_valid;
  logic dbg_valid_ff, nxt_dbg_valid;
  logic dbg_refused_ff, nxt_dbg_refused;
  logic err_ff, nxt_err;
  logic [7:0] mem_rdata;
  mem_cmd_t cmd;
  logic fw_wr, dbg_any, exec_locked;

  function automatic logic page_locked(input logic [3:0] page,
                                       input logic [7:0] lock);
    logic [7:0] n;
    n = ~lock;
    page_locked = ({4'h0, page} < n) ||
                  (page == LOCK_PAGE && n != 8'h00);
  endfunction

  function automatic logic is_rsvd(input logic [15:0] a);
    is_rsvd = (a[15:13] != 3'h0) || (a[12:9] == RSVD_PAGE);
  endfunction

  function automatic key_state_t key_after(input key_state_t k,
                                           input logic [7:0] d);
    key_after = KEY_DEAD;
    if (k == KEY_LOCKED && d == KEY_CODE1)
      key_after = KEY_FIRST;
    else if (k == KEY_FIRST && d == KEY_CODE2)
      key_after = KEY_OPEN;
  endfunction

  // Data-memory reads are never decoded here; they stay on external RAM
  assign fw_wr = i_dmem_wr && ctl_ff[WE_BIT];
  assign o_external_data_ram_wr = i_dmem_wr && !ctl_ff[WE_BIT];
  assign exec_locked = page_locked(i_pc[12:9], lock_ff);
  assign dbg_any = i_dbg_rd || i_dbg_wr || i_dbg_erase || i_dbg_dev_erase;
  assign o_stall = (state_ff != ST_IDLE);
  assign o_dbg_ready = (state_ff == ST_IDLE) && !i_cmem_rd && !i_dmem_wr;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_key = key_ff;
    nxt_ctl = ctl_ff;
    nxt_rt = rt_ff;
    nxt_lock = lock_ff;
    nxt_tmr = tmr_ff;
    nxt_base = base_ff;
    nxt_sfr_rdata = sfr_rdata_ff;
    nxt_code_valid = 1'b0;
    nxt_dbg_valid = 1'b0;
    nxt_dbg_refused = 1'b0;
    nxt_err = 1'b0;
    cmd = '0;
    if (i_sfr_wr)
    begin
      if (i_sfr_addr == SFR_PSC_ADDR)
        nxt_ctl = i_sfr_wdata[EE_BIT:WE_BIT];
      if (i_sfr_addr == SFR_SCALE_ADDR)
        nxt_rt = i_sfr_wdata[RT_BIT];
      if (i_sfr_addr == SFR_KEY_ADDR)
        nxt_key = key_after(key_ff, i_sfr_wdata);
    end
    if (i_sfr_rd)
    begin
      nxt_sfr_rdata = 8'h00;
      if (i_sfr_addr == SFR_PSC_ADDR)
        nxt_sfr_rdata = {6'h00, ctl_ff};
      if (i_sfr_addr == SFR_SCALE_ADDR)
        nxt_sfr_rdata = {3'h0, rt_ff, 4'h0};
      if (i_sfr_addr == SFR_KEY_ADDR)
        nxt_sfr_rdata = {6'h00, key_ff};
    end
    unique case (state_ff)
      ST_BOOT:
      begin
        cmd.re = 1'b1;
        cmd.addr = LOCK_ADDR;
        nxt_state = ST_BOOT_LD;
      end
      ST_BOOT_LD:
      begin
        nxt_lock = mem_rdata;
        nxt_state = ST_IDLE;
      end
      ST_IDLE:
      begin
        nxt_tmr = '0;
        if (i_cmem_rd)
        begin
          if (is_rsvd(i_cmem_addr))
            nxt_err = 1'b1;
          else if (!exec_locked && page_locked(i_cmem_addr[12:9], lock_ff)
                   && i_cmem_addr[12:0] != LOCK_ADDR)
            nxt_err = 1'b1;
          else
          begin
            cmd.re = 1'b1;
            cmd.addr = i_cmem_addr[12:0];
            nxt_code_valid = 1'b1;
          end
        end
        else if (fw_wr)
        begin
          if (is_rsvd(i_dmem_addr))
            nxt_err = 1'b1;
          else if (ctl_ff[EE_BIT] && i_dmem_addr[12:9] == LOCK_PAGE)
            nxt_err = 1'b1;
          else if (!exec_locked && page_locked(i_dmem_addr[12:9], lock_ff))
            nxt_err = 1'b1;
          else if (key_ff != KEY_OPEN)
            nxt_key = KEY_DEAD;
          else if (ctl_ff[EE_BIT])
          begin
            nxt_base = i_dmem_addr[12:9];
            nxt_state = ST_ERASE;
          end
          else if (i_dmem_addr[12:0] == LOCK_ADDR)
            nxt_key = KEY_LOCKED;
          else
          begin
            cmd.we = 1'b1;
            cmd.addr = i_dmem_addr[12:0];
            cmd.wdata = i_dmem_wdata;
            nxt_state = ST_PROG;
          end
        end
        else if (dbg_any && !i_dmem_wr)
        begin
          if (i_dbg_dev_erase)
          begin
            nxt_lock = ERASED_BYTE;
            nxt_state = ST_DEV_ERASE;
          end
          else if (i_dbg_addr[12:9] == RSVD_PAGE ||
                   page_locked(i_dbg_addr[12:9], lock_ff))
            nxt_dbg_refused = 1'b1;
          else if (i_dbg_rd && i_dbg_addr == LOCK_ADDR && lock_ff != 8'hFF)
            nxt_dbg_refused = 1'b1;
          else if (i_dbg_rd)
          begin
            cmd.re = 1'b1;
            cmd.addr = i_dbg_addr;
            nxt_dbg_valid = 1'b1;
          end
          else if (i_dbg_erase)
          begin
            nxt_base = i_dbg_addr[12:9];
            nxt_state = ST_ERASE;
          end
          else
          begin
            cmd.we = 1'b1;
            cmd.addr = i_dbg_addr;
            cmd.wdata = i_dbg_wdata;
            if (i_dbg_addr == LOCK_ADDR)
              nxt_lock = lock_ff & i_dbg_wdata;
            nxt_state = ST_PROG;
          end
        end
      end
      ST_PROG:
      begin
        nxt_tmr = tmr_ff + 1'b1;
        if (tmr_ff == TMR_W'(WRITE_CYCLES - 1))
        begin
          // A disabled key stays disabled until reset
          if (key_ff != KEY_DEAD)
            nxt_key = KEY_LOCKED;
          nxt_state = ST_IDLE;
        end
      end
      ST_ERASE, ST_DEV_ERASE:
      begin
        nxt_tmr = tmr_ff + 1'b1;
        // Erase walks one byte per cycle inside the minimum erase time
        if (state_ff == ST_ERASE && tmr_ff < TMR_W'(PAGE_BYTES))
        begin
          cmd.set_ff = 1'b1;
          cmd.addr = {base_ff, tmr_ff[PAGE_LSB-1:0]};
          if (base_ff == LOCK_PAGE)
            nxt_lock = ERASED_BYTE;
        end
        if (state_ff == ST_DEV_ERASE && tmr_ff < TMR_W'(FLASH_BYTES))
        begin
          cmd.set_ff = 1'b1;
          cmd.addr = tmr_ff[FLASH_AW-1:0];
        end
        if (tmr_ff == TMR_W'(ERASE_CYCLES - 1))
        begin
          if (state_ff == ST_ERASE && key_ff != KEY_DEAD)
            nxt_key = KEY_LOCKED;
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff <= ST_BOOT;
      key_ff <= KEY_LOCKED;
      ctl_ff <= PSC_RESET;
      rt_ff <= RT_RESET;
      lock_ff <= 8'h00;
      tmr_ff <= '0;
      base_ff <= 4'h0;
      sfr_rdata_ff <= 8'h00;
      code_valid_ff <= 1'b0;
      dbg_valid_ff <= 1'b0;
      dbg_refused_ff <= 1'b0;
      err_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      key_ff <= nxt_key;
      ctl_ff <= nxt_ctl;
      rt_ff <= nxt_rt;
      lock_ff <= nxt_lock;
      tmr_ff <= nxt_tmr;
      base_ff <= nxt_base;
      sfr_rdata_ff <= nxt_sfr_rdata;
      code_valid_ff <= nxt_code_valid;
      dbg_valid_ff <= nxt_dbg_valid;
      dbg_refused_ff <= nxt_dbg_refused;
      err_ff <= nxt_err;
    end
  end

  flash_store #(
    .DEPTH(FLASH_BYTES)
  ) u_store (
    .i_ref_clk(i_ref_clk),
    .i_cmd(cmd),
    .o_rdata(mem_rdata)
  );

  assign o_sfr_rdata = sfr_rdata_ff;
  assign o_code_valid = code_valid_ff;
  assign o_dbg_valid = dbg_valid_ff;
  assign o_dbg_refused = dbg_refused_ff;
  assign o_flash_rdata = mem_rdata;
  assign o_flash_err = err_ff;
  assign o_read_time_sel = rt_ff;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_key_opened;
    key_ff == KEY_FIRST ##1 key_ff == KEY_OPEN;
  endsequence

  chk_external_data_ram_steer: assert property (
    i_dmem_wr && !ctl_ff[WE_BIT] |-> o_external_data_ram_wr && nxt_state == state_ff)
    else $error("write with enable low not sent to external RAM");
  chk_erase_enables: assert property (
    state_ff == ST_IDLE && nxt_state == ST_ERASE && !dbg_any
      |-> ctl_ff == 2'h3 && key_ff == KEY_OPEN)
    else $error("erase started without both enables");
  chk_open_order: assert property (
    $rose(key_ff == KEY_OPEN) |-> $past(key_ff) == KEY_FIRST)
    else $error("unlock without first key code");
  chk_dead_sticky: assert property (
    key_ff == KEY_DEAD |=> key_ff == KEY_DEAD)
    else $error("disabled key state left before reset");
  chk_prog_time: assert property (
    state_ff == ST_PROG && nxt_state == ST_IDLE
      |-> tmr_ff == TMR_W'(WRITE_CYCLES - 1) ##1
      key_ff == (($past(key_ff) == KEY_DEAD) ? KEY_DEAD : KEY_LOCKED))
    else $error("program time or relock wrong");
  chk_relock_after: assert property (
    s_key_opened ##1 fw_wr && state_ff == ST_IDLE && !nxt_err && !i_cmem_rd
      |=> key_ff != KEY_OPEN || o_stall)
    else $error("key not consumed by operation");
  chk_erase_relock: assert property (
    state_ff == ST_ERASE && nxt_state == ST_IDLE && key_ff == KEY_OPEN
      |=> key_ff == KEY_LOCKED)
    else $error("key still open after erase");
  chk_rsvd_err: assert property (
    state_ff == ST_IDLE && i_cmem_rd && is_rsvd(i_cmem_addr)
      |=> o_flash_err && !o_code_valid)
    else $error("reserved read did not raise flash error");
  chk_stall_busy: assert property (
    state_ff == ST_IDLE && nxt_state == ST_ERASE |=> o_stall [*8])
    else $error("core not stalled during erase");
  chk_dbg_lockrd: assert property (
    o_dbg_ready && i_dbg_rd && !i_dbg_dev_erase && i_dbg_addr == LOCK_ADDR
      && lock_ff != 8'hFF |=> o_dbg_refused && !o_dbg_valid)
    else $error("debug read of lock byte while locked");
  chk_lock_fw_wr: assert property (
    state_ff == ST_IDLE && fw_wr && !dbg_any |-> !(cmd.we
      && cmd.addr == LOCK_ADDR))
    else $error("firmware changed lock byte");
endmodule
`default_nettype wire

// ---- sim/dbg_port_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dbg_port_model (
  input wire logic i_clk,         // Core clock
  input wire logic i_go,          // Start one request
  input wire logic [1:0] i_op,    // 0 read, 1 erase, 2 dev erase, 3 program
  input wire logic [7:0] i_wdata, // Program data
  input wire logic [12:0] i_addr, // Target address
  input wire logic i_ready,       // Request taken
  input wire logic i_valid,       // Read data valid
  input wire logic i_refused,     // Request blocked
  input wire logic [7:0] i_rdata, // Read data
  output logic o_rd,              // Read request
  output logic o_erase,           // Page erase request
  output logic o_dev_erase,       // Device erase request
  output logic o_wr,              // Byte program request
  output logic [7:0] o_wdata,     // Program data
  output logic [12:0] o_addr,     // Request address
  output logic o_busy,            // Request outstanding
  output logic o_got_valid,       // Answer was data
  output logic o_got_refused,     // Answer was a refusal
  output logic [7:0] o_data       // Captured read data
);
  logic [1:0] st = 2'h0;
  logic [1:0] n = 2'h0;
  initial
  begin
    {o_rd, o_erase, o_dev_erase, o_wr, o_got_valid, o_got_refused} = 6'h00;
    o_addr = 13'h1555;
    o_wdata = 8'h00;
    o_data = 8'h00;
  end
  assign o_busy = (st != 2'h0);
  always @(posedge i_clk)
  begin
    case (st)
      2'h0:
        if (i_go)
        begin
          o_rd <= (i_op == 2'h0);
          o_erase <= (i_op == 2'h1);
          // Only way to lift protection is a whole-device erase
          o_dev_erase <= (i_op == 2'h2);
          o_wr <= (i_op == 2'h3);
          o_wdata <= i_wdata;
          o_addr <= i_addr;
          o_got_valid <= 1'b0;
          o_got_refused <= 1'b0;
          st <= 2'h1;
        end
      2'h1:
        if (i_ready)
        begin
          {o_rd, o_erase, o_dev_erase, o_wr} <= 4'h0;
          // Released lines must not keep the old address
          o_addr <= ~o_addr;
          o_wdata <= ~o_wdata;
          n <= 2'h0;
          st <= 2'h2;
        end
      default:
      begin
        n <= n + 2'h1;
        if (i_valid)
          o_data <= i_rdata;
        o_got_valid <= o_got_valid | i_valid;
        o_got_refused <= o_got_refused | i_refused;
        if (i_valid || i_refused || n == 2'h2)
          st <= 2'h0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- sim/flash_write_erase_security_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_write_erase_security_tb_top;
  import flash_sec_pkg::*;
  localparam int WC = 4;
  localparam int EC = 8192;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sw = 1'b0, sr = 1'b0, crd = 1'b0, dwr = 1'b0, go = 1'b0;
  logic [7:0] sa = 8'h00, sd = 8'h00, dd = 8'h00, gw = 8'h00;
  logic [15:0] pc = 16'h0000, ca = 16'h0000, da = 16'h0000;
  logic [1:0] op = 2'h0;
  logic [12:0] ga = 13'h0000, d_addr;
  logic [7:0] srd, frd, gd, d_wd;
  logic xw, stall, cv, ferr, rts, rdy, dv, dref, d_rd, d_er, d_de;
  logic busy, gv, gr, xs, es, d_wr;
  int failures = 0;
  int n_compared = 0;
  int n;
  always #25 clk = ~clk;
  flash_write_erase_security #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC))
    u_flash_write_erase_security (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_sfr_wr(sw), .i_sfr_rd(sr),
    .i_sfr_addr(sa), .i_sfr_wdata(sd), .o_sfr_rdata(srd), .i_pc(pc),
    .i_cmem_rd(crd), .i_cmem_addr(ca), .i_dmem_wr(dwr), .i_dmem_addr(da),
    .i_dmem_wdata(dd), .o_external_data_ram_wr(xw), .o_stall(stall),
    .o_code_valid(cv), .i_dbg_rd(d_rd), .i_dbg_wr(d_wr),
    .i_dbg_erase(d_er), .i_dbg_dev_erase(d_de), .i_dbg_addr(d_addr),
    .i_dbg_wdata(d_wd), .o_dbg_ready(rdy), .o_dbg_valid(dv),
    .o_dbg_refused(dref), .o_flash_rdata(frd), .o_flash_err(ferr),
    .o_read_time_sel(rts));
  dbg_port_model u_dbg_port_model (.i_clk(clk), .i_go(go), .i_op(op),
    .i_addr(ga), .i_wdata(gw), .o_wr(d_wr), .o_wdata(d_wd),
    .i_ready(rdy), .i_valid(dv), .i_refused(dref),
    .i_rdata(frd), .o_rd(d_rd), .o_erase(d_er), .o_dev_erase(d_de),
    .o_addr(d_addr), .o_busy(busy), .o_got_valid(gv),
    .o_got_refused(gr), .o_data(gd));
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic idle(input int lim, output int k);
    k = 0;
    #1;
    while (stall !== 1'b0 && k < lim)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= lim)
    begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic swr(input logic [7:0] a, d);
    @(posedge clk);
    {sw, sa, sd} <= {1'b1, a, d};
    @(posedge clk);
    sw <= 1'b0;
  endtask
  task automatic sck(input logic [7:0] a, e);
    @(posedge clk);
    {sr, sa} <= {1'b1, a};
    @(posedge clk);
    sr <= 1'b0;
    #1 chk("sfr", srd, e);
  endtask
  task automatic unlock;
    swr(SFR_KEY_ADDR, KEY_CODE1);
    swr(SFR_KEY_ADDR, KEY_CODE2);
  endtask
  task automatic cck(input logic [15:0] p, a, input logic [7:0] e,
                     input logic er);
    int k;
    idle(20, k);
    @(posedge clk);
    {pc, crd, ca} <= {p, 1'b1, a};
    @(posedge clk);
    crd <= 1'b0;
    #1 k = 0;
    while (cv !== 1'b1 && ferr !== 1'b1 && k < 3)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk("code_answer", cv | ferr, 1'b1);
    chk("code_err", ferr, er);
    if (!er)
      chk("code_data", frd, e);
  endtask
  // Returns stall length; external_data_ram steer lands in xs, flash error in es
  task automatic dw(input logic [15:0] p, a, input logic [7:0] d,
                    input logic ee, output int k);
    idle(20, k);
    @(posedge clk);
    {pc, dwr, da, dd} <= {p, 1'b1, a, d};
    #1 xs = xw;
    @(posedge clk);
    dwr <= 1'b0;
    #1 es = ferr;
    chk("flash_err_seen", es, ee);
    idle(EC + 50, k);
  endtask
  task automatic dbg(input logic [1:0] o, input logic [12:0] a,
                     input logic ev, e);
    int k;
    idle(EC + 50, k);
    @(posedge clk);
    {go, op, ga} <= {1'b1, o, a};
    @(posedge clk);
    go <= 1'b0;
    #1 k = 0;
    while (busy === 1'b1 && k < 20)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk("dbg_done", busy, 1'b0);
    chk("dbg_valid", gv, ev);
    chk("dbg_refused", gr, e);
  endtask
  initial
  begin
    #1;
    for (int i = 0; i < FLASH_BYTES; i++)
      u_flash_write_erase_security.u_store.mem[i] = i[7:0];
    u_flash_write_erase_security.u_store.mem[13'h0600] = 8'hF0;
    u_flash_write_erase_security.u_store.mem[LOCK_ADDR] = 8'hFD;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    sck(SFR_PSC_ADDR, 8'h00);
    sck(SFR_SCALE_ADDR, 8'h00);
    sck(SFR_KEY_ADDR, 8'h00);
    swr(SFR_SCALE_ADDR, 8'hFF);
    sck(SFR_SCALE_ADDR, 8'h10);
    chk("read_time", rts, 1'b1);
    swr(SFR_PSC_ADDR, 8'hFF);
    sck(SFR_PSC_ADDR, 8'h03);
    sck(8'h80, 8'h00);
    cck(16'h0800, 16'h0601, 8'h01, 1'b0);
    cck(16'h0800, 16'h0400, 8'h00, 1'b0);
    cck(16'h0800, 16'h0100, 8'h00, 1'b1);
    cck(16'h0800, 16'h1DFF, 8'hFD, 1'b0);
    cck(16'h0800, 16'h1C05, 8'h00, 1'b1);
    cck(16'h0800, 16'h1E00, 8'h00, 1'b1);
    cck(16'h0000, 16'h0100, 8'h00, 1'b0);
    swr(SFR_PSC_ADDR, 8'h02);
    dw(16'h0800, 16'h0400, 8'h00, 1'b0, n);
    chk("external_data_ram_steer", xs, 1'b1);
    chk("no_stall", n, 0);
    sck(SFR_KEY_ADDR, 8'h00);
    swr(SFR_PSC_ADDR, 8'h01);
    swr(SFR_KEY_ADDR, KEY_CODE1);
    sck(SFR_KEY_ADDR, 8'h01);
    swr(SFR_KEY_ADDR, KEY_CODE2);
    sck(SFR_KEY_ADDR, 8'h02);
    dw(16'h0000, 16'h0600, 8'h3C, 1'b0, n);
    chk("flash_steer", xs, 1'b0);
    chk("write_stall", n, WC);
    sck(SFR_KEY_ADDR, 8'h00);
    cck(16'h0000, 16'h0600, 8'h30, 1'b0);
    swr(SFR_PSC_ADDR, 8'h03);
    unlock();
    dw(16'h0800, 16'h0A10, 8'h00, 1'b0, n);
    chk("erase_stall", n, EC);
    cck(16'h0800, 16'h0A00, ERASED_BYTE, 1'b0);
    cck(16'h0800, 16'h0A10, ERASED_BYTE, 1'b0);
    unlock();
    dw(16'h0000, 16'h1C00, 8'h00, 1'b1, n);
    chk("lock_erase_err", es, 1'b1);
    chk("lock_erase_stall", n, 0);
    dbg(2'h0, 13'h0601, 1'b1, 1'b0);
    chk("dbg_data", gd, 8'h01);
    dbg(2'h0, 13'h0100, 1'b0, 1'b1);
    dbg(2'h0, LOCK_ADDR, 1'b0, 1'b1);
    dbg(2'h1, 13'h1C00, 1'b0, 1'b1);
    dbg(2'h1, 13'h1E00, 1'b0, 1'b1);
    dbg(2'h3, 13'h0100, 1'b0, 1'b1);
    dbg(2'h2, 13'h0000, 1'b0, 1'b0);
    dbg(2'h0, LOCK_ADDR, 1'b1, 1'b0);
    chk("lock_after_erase", gd, ERASED_BYTE);
    cck(16'h0800, 16'h0100, ERASED_BYTE, 1'b0);
    gw <= 8'h5A;
    dbg(2'h3, 13'h0400, 1'b0, 1'b0);
    dbg(2'h0, 13'h0400, 1'b1, 1'b0);
    chk("dbg_prog", gd, 8'h5A);
    swr(SFR_KEY_ADDR, 8'h12);
    sck(SFR_KEY_ADDR, 8'h03);
    swr(SFR_KEY_ADDR, KEY_CODE1);
    sck(SFR_KEY_ADDR, 8'h03);
    swr(SFR_PSC_ADDR, 8'h01);
    dw(16'h0800, 16'h0400, 8'h00, 1'b0, n);
    chk("dead_no_stall", n, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
